// ### design/dlr_rtc.sv
// dual low-frequency real-time counter with strobes, capture, sampling and avalon-mm registers
`timescale 1ns/1ns
`default_nettype none
// How it works
// - the seconds unit runs from the synchronised crystal input, the flexible unit from crystal or internal
// - a count equal to the alarm value raises an alarm status and interrupt
// - a signed trim correction is added every programmed interval of ticks
// - the seconds unit always divides its crystal ticks by 32768
// - the flexible unit divides by two to the programmed exponent, 0 to 15
// - seconds use the crystal; flexible uses crystal or internal per source select
// - four strobe outputs are generated by the flexible time base
// - each strobe divides the flexible unit's selected source, crystal or internal, with one-cycle resolution
// - after reset nothing counts until software enables each unit
// - the seconds unit has one absolute, non-repeating alarm in seconds
// - the flexible unit has an absolute alarm and one every 60 units
// - a capture pin rising edge latches the flexible count and flags it while that unit is enabled
// - each strobe samples three inputs and can flag activity on them
module dlr_rtc (
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    input  wire logic [dlr_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [31:0]                  avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output logic      [31:0]                  avs_readdata,
    output logic                              avs_waitrequest,
    input  wire logic                         low_freq_crystal_osc,
    input  wire logic                         low_freq_internal_osc,
    input  wire logic                         capture_in,
    input  wire logic [dlr_pkg::NSTRB*dlr_pkg::NSAMP-1:0] sample_in,
    output logic      [dlr_pkg::NSTRB-1:0]    strobe_out,
    output logic                              irq
);
    import dlr_pkg::*;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // =====================================================================
    // declarations
    logic [PIN_W-1:0]    pin_w, s1_q, s2_q, s3_q, filt_q, filt_d, rise;
    dlr_bus_t            bus_q, bus_d;
    logic                wait_q, wait_d, wr_now;
    logic [31:0]         rdata_q, rdata_d, rd_mux, wmask;
    logic [31:0]         ctrl_q, ctrl_d, cap_q, cap_d;
    logic [31:0]         alm_q[2], alm_d[2], trim_q[2], trim_d[2], cnt_q[2], cnt_d[2], adj_ext[2];
    logic [31:0]         strb_cfg_q[NSTRB], strb_cfg_d[NSTRB];
    logic [PRE_W-1:0]    pre_q[2], pre_d[2], mask[2];
    logic [TRIM_IVL_W-1:0] tcnt_q[2], tcnt_d[2];
    logic [1:0]          en, trim_on, src_tick, tick, trim_now, alm_ev, cnt_ld;
    logic [ST_W-1:0]     ien_q, ien_d, stat_q, stat_d, clr, ev;
    logic [5:0]          per_q, per_d;
    logic                irq_q, irq_d;
    logic [STRB_W-1:0]   scnt_q[NSTRB], scnt_d[NSTRB], per[NSTRB], hi[NSTRB];
    logic [NSTRB-1:0]    strb_q, strb_d, samp_ev;
    logic [NSTRB*NSAMP-1:0] samp_q, samp_d;

    // =====================================================================
    // pin synchronisers: a change counts once stages two and three agree
    assign pin_w = {sample_in, capture_in, low_freq_internal_osc, low_freq_crystal_osc};
    always_comb begin
        filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
        rise   = filt_d & ~filt_q;
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            filt_q <= '0;
        end else begin
            s1_q   <= pin_w;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= filt_d;
        end
    end

    // =====================================================================
    // avalon-mm slave: one wait cycle, then a single acknowledge cycle
    assign wmask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wr_now = (bus_q == BUS_ACK) && avs_write;
    always_comb begin
        bus_d   = bus_q;
        wait_d  = 1'b1;
        rdata_d = rdata_q;
        case (bus_q)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_d   = BUS_ACK;
                    wait_d  = 1'b0;
                    rdata_d = avs_read ? rd_mux : '0;
                end
            end
            BUS_ACK: bus_d = BUS_IDLE;
            default: bus_d = BUS_IDLE;
        endcase
    end

    // read mux; unmapped and write-only addresses read zero
    always_comb begin
        rd_mux = '0;
        case (avs_address)
            OFS_CTRL:    rd_mux = ctrl_q;
            OFS_CNT[0]:  rd_mux = cnt_q[0];
            OFS_CNT[1]:  rd_mux = cnt_q[1];
            OFS_ALM[0]:  rd_mux = alm_q[0];
            OFS_ALM[1]:  rd_mux = alm_q[1];
            OFS_TRIM[0]: rd_mux = trim_q[0];
            OFS_TRIM[1]: rd_mux = trim_q[1];
            OFS_CAPT:    rd_mux = cap_q;
            OFS_STAT:    rd_mux = 32'(stat_q);
            OFS_IEN:     rd_mux = 32'(ien_q);
            OFS_SAMP:    rd_mux = 32'(samp_q);
            default: begin
                if (avs_address[ADDR_W-1:4] == OFS_STRB0[ADDR_W-1:4] && avs_address[1:0] == 2'h0) begin
                    rd_mux = strb_cfg_q[avs_address[3:2]];
                end
            end
        endcase
    end

    // software-written registers with byte enables
    always_comb begin
        ctrl_d = ctrl_q;
        ien_d  = ien_q;
        clr    = '0;
        cnt_ld = '0;
        for (int u = 0; u < 2; u++) begin
            alm_d[u]  = alm_q[u];
            trim_d[u] = trim_q[u];
            if (wr_now && avs_address == OFS_ALM[u]) alm_d[u] = (alm_q[u] & ~wmask) | (avs_writedata & wmask);
            if (wr_now && avs_address == OFS_TRIM[u]) trim_d[u] = (trim_q[u] & ~wmask) | (avs_writedata & wmask);
            cnt_ld[u] = wr_now && avs_address == OFS_CNT[u];
        end
        for (int c = 0; c < NSTRB; c++) begin
            strb_cfg_d[c] = strb_cfg_q[c];
            if (wr_now && avs_address == OFS_STRB0 + 8'(c * 4)) begin
                strb_cfg_d[c] = (strb_cfg_q[c] & ~wmask) | (avs_writedata & wmask);
            end
        end
        if (wr_now && avs_address == OFS_CTRL) ctrl_d = (ctrl_q & ~wmask) | (avs_writedata & wmask);
        if (wr_now && avs_address == OFS_IEN) begin
            ien_d = (ien_q & ~wmask[ST_W-1:0]) | (avs_writedata[ST_W-1:0] & wmask[ST_W-1:0]);
        end
        if (wr_now && avs_address == OFS_ICLR) clr = avs_writedata[ST_W-1:0] & wmask[ST_W-1:0];
    end

    // =====================================================================
    // counter units: index 0 seconds, index 1 flexible
    always_comb begin
        src_tick[0] = rise[PIN_XTAL];
        src_tick[1] = ctrl_q[CTRL_SRC] ? rise[PIN_LOSC] : rise[PIN_XTAL];
        mask[0]     = {PRE_W{1'b1}};
        mask[1]     = PRE_W'((16'h0001 << ctrl_q[CTRL_EXP_LO +: EXP_W]) - 16'h0001);
        for (int u = 0; u < 2; u++) begin
            en[u]       = ctrl_q[CTRL_SEC_EN + u];
            trim_on[u]  = ctrl_q[CTRL_SEC_TRIM + u];
            adj_ext[u]  = {{(32 - TRIM_ADJ_W){trim_q[u][TRIM_ADJ_LO + TRIM_ADJ_W - 1]}},
                           trim_q[u][TRIM_ADJ_LO +: TRIM_ADJ_W]};
            pre_d[u]    = pre_q[u];
            cnt_d[u]    = cnt_q[u];
            tcnt_d[u]   = tcnt_q[u];
            tick[u]     = 1'b0;
            trim_now[u] = 1'b0;
            alm_ev[u]   = 1'b0;
            if (en[u] && src_tick[u]) begin
                pre_d[u] = pre_q[u] + 15'h0001;
                tick[u]  = (pre_q[u] & mask[u]) == mask[u];
            end
            if (tick[u]) begin
                trim_now[u] = trim_on[u] && tcnt_q[u] == trim_q[u][TRIM_IVL_LO +: TRIM_IVL_W];
                tcnt_d[u]   = trim_now[u] ? '0 : tcnt_q[u] + 16'h0001;
                cnt_d[u]    = cnt_q[u] + 32'h0000_0001 + (trim_now[u] ? adj_ext[u] : '0);
                alm_ev[u]   = cnt_d[u] == alm_q[u];
            end
            if (cnt_ld[u]) cnt_d[u] = (cnt_q[u] & ~wmask) | (avs_writedata & wmask);
        end
    end

    // =====================================================================
    // strobe channels with input sampling
    always_comb begin
        samp_d  = samp_q;
        samp_ev = '0;
        for (int c = 0; c < NSTRB; c++) begin
            per[c]    = strb_cfg_q[c][STRB_PER_LO +: STRB_W];
            hi[c]     = strb_cfg_q[c][STRB_HI_LO +: STRB_W];
            scnt_d[c] = scnt_q[c];
            strb_d[c] = strb_q[c];
            if (!en[1] || per[c] == '0) begin
                scnt_d[c] = '0;
                strb_d[c] = 1'b0;
            end else if (src_tick[1]) begin
                scnt_d[c] = (scnt_q[c] == per[c] - 16'h0001) ? '0 : scnt_q[c] + 16'h0001;
                strb_d[c] = scnt_d[c] < hi[c];
            end
            if (strb_d[c] && !strb_q[c]) begin
                samp_d[c*NSAMP +: NSAMP] = filt_q[PIN_SAMP + c*NSAMP +: NSAMP];
                samp_ev[c] = |((filt_q[PIN_SAMP + c*NSAMP +: NSAMP] ^ samp_q[c*NSAMP +: NSAMP])
                               & ctrl_q[CTRL_MASK_LO + c*NSAMP +: NSAMP]);
            end
        end
    end

    // =====================================================================
    // events, periodic alarm, capture, sticky status and interrupt
    always_comb begin
        per_d = per_q;
        cap_d = cap_q;
        ev    = '0;
        ev[ST_SEC_ALM] = alm_ev[0];
        ev[ST_FLX_ALM] = alm_ev[1];
        if (tick[1]) begin
            per_d = (per_q == PER_LAST) ? '0 : per_q + 6'h01;
            ev[ST_FLX_PER] = per_q == PER_LAST;
        end
        if (en[1] && rise[PIN_CAP]) begin
            cap_d       = cnt_q[1];
            ev[ST_CAP]  = 1'b1;
        end
        ev[ST_SAMP_LO +: NSTRB] = samp_ev;
        stat_d = (stat_q & ~clr) | ev;                                           // set wins over clear
        irq_d  = |(stat_d & ien_d);                                              // no lag after enable writes
    end

    // registers of all groups except the pin synchronisers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bus_q   <= BUS_IDLE;
            wait_q  <= 1'b1;
            rdata_q <= '0;
            ctrl_q  <= '0;
            ien_q   <= '0;
            stat_q  <= '0;
            cap_q   <= '0;
            per_q   <= '0;
            irq_q   <= 1'b0;
            strb_q  <= '0;
            samp_q  <= '0;
            for (int u = 0; u < 2; u++) begin
                alm_q[u]  <= '0;
                trim_q[u] <= '0;
                cnt_q[u]  <= '0;
                pre_q[u]  <= '0;
                tcnt_q[u] <= '0;
            end
            for (int c = 0; c < NSTRB; c++) begin
                strb_cfg_q[c] <= '0;
                scnt_q[c]     <= '0;
            end
        end else begin
            bus_q   <= bus_d;
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
            ctrl_q  <= ctrl_d;
            ien_q   <= ien_d;
            stat_q  <= stat_d;
            cap_q   <= cap_d;
            per_q   <= per_d;
            irq_q   <= irq_d;
            strb_q  <= strb_d;
            samp_q  <= samp_d;
            for (int u = 0; u < 2; u++) begin
                alm_q[u]  <= alm_d[u];
                trim_q[u] <= trim_d[u];
                cnt_q[u]  <= cnt_d[u];
                pre_q[u]  <= pre_d[u];
                tcnt_q[u] <= tcnt_d[u];
            end
            for (int c = 0; c < NSTRB; c++) begin
                strb_cfg_q[c] <= strb_cfg_d[c];
                scnt_q[c]     <= scnt_d[c];
            end
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign strobe_out      = strb_q;
    assign irq             = irq_q;

    // =====================================================================
    // assertions
    a_flx_alarm_flag: assert property (alm_ev[1] |=> stat_q[ST_FLX_ALM])
        else $error("flexible alarm match not flagged");
    a_trim_step: assert property ((trim_now[1] && !cnt_ld[1]) |=>
        cnt_q[1] == $past(cnt_q[1]) + 32'h0000_0001 + $past(adj_ext[1]))
        else $error("trim correction not applied");
    a_sec_divide: assert property ((en[0] && src_tick[0] && pre_q[0] != {PRE_W{1'b1}}) |-> !tick[0])
        else $error("seconds ticked before full prescale");
    a_flex_div_one: assert property ((en[1] && src_tick[1] && ctrl_q[CTRL_EXP_LO +: EXP_W] == '0) |-> tick[1])
        else $error("divide by one missed a tick");
    a_src_select: assert property ((en[1] && ctrl_q[CTRL_SRC] && !rise[PIN_LOSC]) |=>
        pre_q[1] == $past(pre_q[1]))
        else $error("flexible prescaler advanced without internal source");
    a_idle_hold: assert property ((!ctrl_q[CTRL_SEC_EN] && !cnt_ld[0]) |=> $stable(cnt_q[0]))
        else $error("seconds count moved while disabled");
    a_periodic_wrap: assert property ((tick[1] && per_q == PER_LAST) |=> per_q == '0 && stat_q[ST_FLX_PER])
        else $error("periodic alarm did not fire at 60 units");
    a_capture_value: assert property ((en[1] && rise[PIN_CAP]) |=>
        cap_q == $past(cnt_q[1]) && stat_q[ST_CAP])
        else $error("capture did not latch the flexible count");
    a_count_wrap: assert property ((tick[1] && !trim_now[1] && !cnt_ld[1] && &cnt_q[1]) |=>
        cnt_q[1] == '0)
        else $error("flexible count did not wrap");
    a_strobe_wrap: assert property ((en[1] && per[0] != '0 && src_tick[1] &&
        scnt_q[0] == per[0] - 16'h0001 && $stable(strb_cfg_q[0])) |=> scnt_q[0] == '0)
        else $error("strobe divider did not wrap at its period");
    a_sample_flag: assert property (samp_ev[0] |=> stat_q[ST_SAMP_LO])
        else $error("sample activity not flagged");
    a_bus_answer: assert property ((bus_q == BUS_IDLE && avs_read) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("read not answered after one wait cycle");

    c_sec_alarm: cover property (alm_ev[0] && ien_q[ST_SEC_ALM] ##1 irq);
    c_capture:   cover property (en[1] && rise[PIN_CAP]);
    c_periodic:  cover property (ev[ST_FLX_PER]);
    c_sample:    cover property (samp_ev != '0);
endmodule
`default_nettype wire

// ### shared/dlr_pkg.sv
// register map, field layout and constants of the dual low-frequency real-time counter
package dlr_pkg;
    // =====================================================================
    // clocks and timing
    localparam int unsigned LF_HZ       = 32768;      // crystal frequency in Hz
    localparam int unsigned SYS_HZ      = 50000000;   // clk_sys rate
    localparam int unsigned SYS_PER_LF  = SYS_HZ / LF_HZ; // system cycles per crystal cycle (least)
    localparam int          PRE_W       = 15;         // prescaler width, divide up to 32768
    localparam int          EXP_W       = 4;          // power-of-two exponent 0..15
    localparam logic [EXP_W-1:0] SEC_EXP = 4'hF;      // seconds unit always divides by 32768
    localparam int          PERIODIC_UNITS = 60;      // periodic alarm interval in prescaled units
    localparam logic [5:0]  PER_LAST    = 6'(PERIODIC_UNITS - 1);
    localparam int          NSTRB       = 4;          // strobe channels
    localparam int          NSAMP       = 3;          // sampled inputs per strobe channel
    // =====================================================================
    // bus and register offsets (byte addresses)
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_CNT [2] = '{8'h04, 8'h10};  // seconds, flexible
    localparam logic [7:0]  OFS_ALM [2] = '{8'h08, 8'h14};
    localparam logic [7:0]  OFS_TRIM[2] = '{8'h0C, 8'h18};
    localparam logic [7:0]  OFS_CAPT    = 8'h1C;
    localparam logic [7:0]  OFS_STAT    = 8'h20;
    localparam logic [7:0]  OFS_IEN     = 8'h24;
    localparam logic [7:0]  OFS_ICLR    = 8'h28;
    localparam logic [7:0]  OFS_SAMP    = 8'h2C;
    localparam logic [7:0]  OFS_STRB0   = 8'h30;      // four words, 16-byte aligned
    // =====================================================================
    // control fields
    localparam int CTRL_SEC_EN   = 0;   // seconds unit enable, flexible at +1
    localparam int CTRL_SRC      = 2;   // low_freq_source_mux: 0 crystal, 1 internal
    localparam int CTRL_EXP_LO   = 4;
    localparam int CTRL_SEC_TRIM = 8;   // seconds trim enable, flexible at +1
    localparam int CTRL_MASK_LO  = 16;  // sample activity masks, 3 bits per channel
    // trim fields
    localparam int TRIM_ADJ_LO = 0;
    localparam int TRIM_ADJ_W  = 8;     // signed correction
    localparam int TRIM_IVL_LO = 16;
    localparam int TRIM_IVL_W  = 16;    // interval in ticks, minus one
    // strobe fields
    localparam int STRB_PER_LO = 0;
    localparam int STRB_W      = 16;
    localparam int STRB_HI_LO  = 16;
    // status bits
    localparam int ST_SEC_ALM  = 0;
    localparam int ST_FLX_ALM  = 1;
    localparam int ST_FLX_PER  = 2;
    localparam int ST_CAP      = 3;
    localparam int ST_SAMP_LO  = 4;
    localparam int ST_W        = 8;
    // synchronised pin positions
    localparam int PIN_XTAL = 0;
    localparam int PIN_LOSC = 1;
    localparam int PIN_CAP  = 2;
    localparam int PIN_SAMP = 3;
    localparam int PIN_W    = PIN_SAMP + NSTRB * NSAMP;
    // bus handshake states
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } dlr_bus_t;
endpackage

// ### verif/dlr_osc_model.sv
// far-side model: crystal and internal low-frequency oscillators producing counted edge bursts
`timescale 1ns/1ns
`default_nettype none
module dlr_osc_model (
    input  wire logic        clk_sys,
    input  wire logic        start,
    input  wire logic [15:0] n_xtal,
    input  wire logic [15:0] n_losc,
    output logic             busy,
    output var logic         low_freq_crystal_osc,
    output var logic         low_freq_internal_osc
);
    logic bx;
    logic bl;
    // both oscillators stand low between bursts
    assign busy = bx | bl;
    // crystal: 4 clk_sys high, 4 low, shared by both units
    initial begin
        bx = 1'b0;
        low_freq_crystal_osc = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (start === 1'b1) begin
                bx = 1'b1;
                for (int i = 0; i < n_xtal; i++) begin
                    repeat (4) @(posedge clk_sys);
                    low_freq_crystal_osc <= 1'b1;
                    repeat (4) @(posedge clk_sys);
                    low_freq_crystal_osc <= 1'b0;
                end
                bx = 1'b0;
            end
        end
    end
    // internal oscillator: 5 high, 5 low, a different rate
    initial begin
        bl = 1'b0;
        low_freq_internal_osc = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (start === 1'b1) begin
                bl = 1'b1;
                for (int i = 0; i < n_losc; i++) begin
                    repeat (5) @(posedge clk_sys);
                    low_freq_internal_osc <= 1'b1;
                    repeat (5) @(posedge clk_sys);
                    low_freq_internal_osc <= 1'b0;
                end
                bl = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the dual low-frequency real-time counter
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import dlr_pkg::*;
    logic        clk_sys, rst, avs_read, avs_write, capture_in, start, busy, xtal, losc, irq, avs_waitrequest;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0]  avs_byteenable, strobe_out, prev;
    logic [11:0] sample_in;
    logic [15:0] n_xtal, n_losc;
    int          error_cnt, n_compared, cycles, seed, e, s, adj, t;
    int          rises [4];

    dlr_rtc i_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .low_freq_crystal_osc(xtal),
        .low_freq_internal_osc(losc), .capture_in(capture_in), .sample_in(sample_in),
        .strobe_out(strobe_out), .irq(irq));
    dlr_osc_model i_osc (.clk_sys(clk_sys), .start(start), .n_xtal(n_xtal), .n_losc(n_losc),
        .busy(busy), .low_freq_crystal_osc(xtal), .low_freq_internal_osc(losc));

    // =====================================================================
    // clock, timeout and strobe rise counting
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        for (int c = 0; c < 4; c++) begin
            if (strobe_out[c] === 1'b1 && prev[c] === 1'b0) rises[c] = rises[c] + 1;
        end
        prev = strobe_out;
        if (cycles == 40000) begin
            error_cnt++;
            stop_test();
        end
    end

    // =====================================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
    endtask
    // burst of oscillator edges, then settle past the pin synchronisers
    task automatic run(input int nx, input int nl);
        n_xtal <= 16'(nx);
        n_losc <= 16'(nl);
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        @(posedge clk_sys);
        while (busy === 1'b1) @(posedge clk_sys);
        repeat (10) @(posedge clk_sys);
    endtask
    // ticks of the selected source, plus trim every ivl+1 ticks
    function automatic logic [31:0] exp_cnt(input int n, input int ex, input int a, input int ivl);
        int tk;
        tk = n >> ex;
        return 32'(tk + a * (tk / (ivl + 1)));
    endfunction
    task automatic stop_test();
        $display("errors %0d, comparisons %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // =====================================================================
    // main sequence
    initial begin
        seed = 32'h3E8F;
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        capture_in = 1'b0;
        sample_in = 12'h000;
        start = 1'b0;
        n_xtal = 16'h0;
        n_losc = 16'h0;
        prev = 4'h0;
        rises = '{default: 0};
        do_reset();
        // idle after reset, unmapped address reads zero
        bus(0, OFS_CTRL, 0); check(rd, 0);
        bus(0, 8'hFC, 0); check(rd, 0);
        run(20, 20);
        bus(0, OFS_CNT[1], 0); check(rd, 0);
        // random prescale, alternating source, other source busy too, then capture
        for (int i = 0; i < 4; i++) begin
            e = $unsigned($random(seed)) % 4;
            s = i % 2;
            t = 8 + $unsigned($random(seed)) % 40;
            do_reset();
            bus(1, OFS_IEN, 32'h8);
            bus(1, OFS_CTRL, 32'(3 | (s << 2) | (e << 4)));
            run(s ? t + 7 : t, s ? t : t + 7);
            bus(0, OFS_CNT[1], 0); check(rd, exp_cnt(t, e, 0, 0));
            bus(0, OFS_CNT[0], 0); check(rd, 0);
            capture_in <= 1'b1;
            repeat (6) @(posedge clk_sys);
            capture_in <= 1'b0;
            repeat (6) @(posedge clk_sys);
            check({31'h0, irq}, 32'h1);
            bus(0, OFS_CAPT, 0); check(rd, exp_cnt(t, e, 0, 0));
        end
        // signed trim, then wrap to zero
        do_reset();
        adj = $random(seed) % 5;
        bus(1, OFS_TRIM[1], {16'h0003, 8'h00, 8'(adj)});
        bus(1, OFS_CTRL, 32'h202);
        run(23, 0);
        bus(0, OFS_CNT[1], 0); check(rd, exp_cnt(23, 0, adj, 3));
        bus(1, OFS_CTRL, 32'h2);
        bus(1, OFS_CNT[1], 32'hFFFF_FFFF);
        run(1, 0);
        bus(0, OFS_CNT[1], 0); check(rd, 0);
        // absolute alarm, clear, then masked periodic alarm
        do_reset();
        bus(1, OFS_ALM[1], 32'h5);
        bus(1, OFS_IEN, 32'h2);
        bus(1, OFS_CTRL, 32'h2);
        run(5, 0);
        check({31'h0, irq}, 32'h1);
        bus(0, OFS_STAT, 0); check(rd, 32'h2);
        bus(1, OFS_ICLR, 32'h2);
        repeat (2) @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        run(55, 0);
        check({31'h0, irq}, 32'h0);
        bus(0, OFS_STAT, 0); check(rd, 32'h4);
        bus(0, OFS_ICLR, 0); check(rd, 0);
        // four strobes of periods 2..5, sampling with activity flags
        do_reset();
        for (int c = 0; c < 4; c++) bus(1, OFS_STRB0 + 8'(4 * c), {16'h0001, 16'(c + 2)});
        bus(1, OFS_IEN, 32'hF0);
        bus(1, OFS_CTRL, 32'h0FFF_0002);
        sample_in <= 12'($random(seed)) | 12'h249;
        repeat (4) @(posedge clk_sys);
        rises = '{default: 0};
        run(60, 0);
        for (int c = 0; c < 4; c++) check(32'(rises[c]), 32'(60 / (c + 2)));
        bus(0, OFS_SAMP, 0); check(rd, {20'h0, sample_in});
        bus(0, OFS_STAT, 0); check(rd, 32'hF4);
        check({31'h0, irq}, 32'h1);
        stop_test();
    end
endmodule
`default_nettype wire
